// ---- logic/pdmd_cic.sv ----
// link-side cic decimator for one pdm channel
`timescale 1ns/10ps
module pdmd_cic
   import pdmd_pkg::*;
(
   // link clock and core reset
   input wire logic pdm_clk_in,
   input wire logic nrst_in,
   // microphone bit and settings from the core
   input wire logic pdm_data_in,
   input wire logic en_in,
   input wire logic [2:0] l2_in,
   input wire logic [1:0] order_in,
   // decimated word held until the next, with its event toggle
   output logic signed [15:0] word_out,
   output logic tgl_out
);
   logic [1:0] rs_q, ds_q, es_q, ora_q, orb_q;
   logic [2:0] l2a_q, l2b_q;
   logic [6:0] cnt_q;
   logic signed [AW-1:0] i1_q, i2_q, i3_q, s_q, c1_q, c2_q;
   logic signed [AW-1:0] bit_v, src, c1, c2, c3, r;
   logic signed [39:0] sc;
   logic [4:0] sh;
   logic run, dec;

   // settings are static while a channel runs, so plain two-stage syncs suffice
   always_ff @(posedge pdm_clk_in) begin
      rs_q <= {rs_q[0], nrst_in};
      ds_q <= {ds_q[0], pdm_data_in};
      es_q <= {es_q[0], en_in};
      l2a_q <= l2_in;
      l2b_q <= l2a_q;
      ora_q <= order_in;
      orb_q <= ora_q;
   end

   assign run = rs_q[1] && es_q[1];
   assign dec = (cnt_q == 7'((8'h01 << l2b_q) - 8'h01));

   always_comb begin
      bit_v = ds_q[1] ? 24'sh000001 : -24'sh000001;
      src = (orb_q == ORD_C) ? i1_q : (orb_q == ORD_B) ? i2_q : i3_q;
      c1 = src - s_q;
      c2 = c1 - c1_q;
      c3 = c2 - c2_q;
      r = (orb_q == ORD_C) ? c1 : (orb_q == ORD_B) ? c2 : c3;
      sh = 5'(orb_q) * 5'(l2b_q);
      sc = (40'(r) <<< CIC_NORM) >>> sh;
   end

   // integrate every bit, comb once per ratio
   always_ff @(posedge pdm_clk_in) begin
      if (!run) begin
         cnt_q <= '0;
         i1_q <= '0;
         i2_q <= '0;
         i3_q <= '0;
         s_q <= '0;
         c1_q <= '0;
         c2_q <= '0;
      end else begin
         i1_q <= i1_q + bit_v;
         i2_q <= i2_q + i1_q;
         i3_q <= i3_q + i2_q;
         cnt_q <= dec ? '0 : cnt_q + 7'h01;
         if (dec) begin
            s_q <= src;
            c1_q <= c1;
            c2_q <= c2;
         end
      end
   end

   always_ff @(posedge pdm_clk_in) begin
      if (!rs_q[1]) begin
         word_out <= '0;
         tgl_out <= 1'b0;
      end else if (run && dec) begin
         word_out <= sat16(sc);
         tgl_out <= ~tgl_out;
      end
   end

   a_cic_decimate: assert property (@(posedge pdm_clk_in) disable iff (!rs_q[1])
      run && dec |=> tgl_out != $past(tgl_out)) else $error("decimated word not flagged");
endmodule

// ---- logic/pdmd_gain.sv ----
// volume, fine gain and mute stage for one record channel
`timescale 1ns/10ps
module pdmd_gain
   import pdmd_pkg::*;
(
   // core clock and reset
   input wire logic clk_in,
   input wire logic nrst_in,
   // filtered sample and its strobe
   input wire logic go_in,
   input wire logic signed [15:0] x_in,
   // level controls
   input wire logic signed [5:0] vol_in,
   input wire logic [2:0] fine_in,
   input wire logic mute_in,
   // output word
   output logic signed [15:0] y_out,
   output logic vld_out
);
   logic signed [5:0] vc;
   logic [5:0] v;
   logic [2:0] q, r, f;
   logic signed [55:0] p1;
   logic signed [39:0] p2;

   always_comb begin
      vc = (vol_in < VOL_MIN) ? VOL_MIN : (vol_in > VOL_MAX) ? VOL_MAX : vol_in;
      // offset so that -12 db is the lowest step
      v = 6'(vc + VOL_OFS);
      q = 3'(v / VOL_STEP_DB);
      r = 3'(v % VOL_STEP_DB);
      // fine trim in 0.1 db steps
      f = (fine_in > FINE_MAX) ? FINE_MAX : fine_in;
      // a bare shift per 6 db would drift by 0.06 db at the top setting
      p1 = ((56'(x_in) * 56'(VOL_TAB[r]) * 56'(VOL_CORR[q])) <<< q) >>> (VOL_SHIFT + CORR_SHIFT);
      p2 = 40'((p1 * 56'(FINE_TAB[f])) >>> FINE_SHIFT);
   end

   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         y_out <= '0;
         vld_out <= 1'b0;
      end else begin
         vld_out <= go_in;
         if (go_in) y_out <= mute_in ? '0 : sat16(p2);
      end
   end

   a_mute_zero: assert property (@(posedge clk_in) disable iff (!nrst_in)
      go_in && mute_in |=> vld_out && y_out == '0) else $error("muted word not zero");
   a_unity_gain: assert property (@(posedge clk_in) disable iff (!nrst_in)
      go_in && !mute_in && vol_in == 6'h00 && fine_in == 3'h0 |=> y_out == $past(x_in))
      else $error("0 db setting does not pass the word unchanged");
endmodule

// ---- logic/pdmd_pkg.sv ----
// shared constants and types for the pdm record decimation path
package pdmd_pkg;
   localparam int AW = 24;
   localparam int COEF_N = 53;
   localparam int IIR_BASE = 0;
   localparam int BQ_BASE = 3;
   localparam int FIR_BASE = 28;
   localparam int BQ_TAPS = 5;
   localparam int COEF_FRAC = 14;
   localparam int CIC_NORM = 15;
   localparam int VOL_SHIFT = 16;
   localparam int FINE_SHIFT = 15;
   localparam int CORR_SHIFT = 15;
   localparam logic signed [15:0] COEF_ONE = 16'sh4000;
   localparam logic [4:0] REC_CHAIN_1 = 5'h01;
   localparam logic [4:0] REC_CHAIN_2 = 5'h02;
   localparam logic [4:0] REC_CHAIN_4 = 5'h04;
   localparam logic [4:0] REC_CHAIN_9 = 5'h09;
   localparam logic [4:0] REC_CHAIN_13 = 5'h0d;
   localparam logic [4:0] REC_CHAIN_LAST = 5'h12;
   localparam logic [4:0] CHAINS_PER_TYPE = 5'h06;
   localparam logic [4:0] MONO_FIRST = 5'h03;
   localparam logic [4:0] OPT_BQ = 5'h01;
   localparam logic [4:0] OPT_FIR = 5'h02;
   localparam logic [2:0] NBQ_AC = 3'h5;
   localparam logic [2:0] NBQ_B = 3'h3;
   localparam logic [4:0] NFIR_AC = 5'h19;
   localparam logic [4:0] NFIR_B = 5'h14;
   localparam logic [7:0] OSR_128 = 8'h80;
   localparam logic [7:0] OSR_64 = 8'h40;
   localparam logic [7:0] OSR_32 = 8'h20;
   localparam logic [2:0] L2_128 = 3'h7;
   localparam logic [2:0] L2_64 = 3'h6;
   localparam logic [2:0] L2_32 = 3'h5;
   localparam logic [1:0] ORD_A = 2'h3;
   localparam logic [1:0] ORD_B = 2'h2;
   localparam logic [1:0] ORD_C = 2'h1;
   localparam logic signed [5:0] VOL_MIN = -6'sh0c;
   localparam logic signed [5:0] VOL_MAX = 6'sh14;
   localparam logic signed [5:0] VOL_OFS = 6'sh0c;
   localparam logic [5:0] VOL_STEP_DB = 6'h06;
   localparam logic [2:0] FINE_MAX = 3'h4;
   localparam logic signed [39:0] SAT_MAX = 40'sh7fff;
   localparam logic signed [39:0] SAT_MIN = -40'sh8000;
   // 0..5 db in 1 db steps, q14
   localparam logic signed [17:0] VOL_TAB [6] = '{18'sh04000, 18'sh047cf, 18'sh05092,
                                                 18'sh05a67, 18'sh0656f, 18'sh071cf};
   // 0 to -0.4 db in 0.1 db steps, q15
   localparam logic signed [17:0] FINE_TAB [5] = '{18'sh08000, 18'sh07e88, 18'sh07d16,
                                                  18'sh07ba7, 18'sh07a3d};
   // trims a plain shift to exact 6 db steps, -12 to +18 db, q15
   localparam logic signed [17:0] VOL_CORR [6] = '{18'sh0809c, 18'sh0804e, 18'sh08000,
                                                  18'sh07fb2, 18'sh07f65, 18'sh07f18};
   typedef enum logic [1:0] {FLT_A = 2'h0, FLT_B = 2'h1, FLT_C = 2'h3} pdmd_flt_e;
   typedef enum logic [2:0] {ST_IDLE = 3'h0, ST_IIR = 3'h1, ST_BQ = 3'h3, ST_FIR = 3'h2,
                             ST_OUT = 3'h6} pdmd_st_e;

   function automatic logic signed [15:0] sat16(input logic signed [39:0] v);
      if (v > SAT_MAX) return 16'sh7fff;
      if (v < SAT_MIN) return 16'sh8000;
      return 16'(v);
   endfunction
endpackage

// ---- logic/pdmd_top.sv ----
// stereo pdm record path: decimation, filter chain, gain and mute
`timescale 1ns/10ps
module pdmd_top
   import pdmd_pkg::*;
(
   // core clock and reset
   input wire logic clk_in,
   input wire logic nrst_in,
   // pdm microphone link
   input wire logic pdm_clk_in,
   input wire logic pdm_data_l_in,
   input wire logic pdm_data_r_in,
   // chain and rate selection
   input wire logic [4:0] rec_chain_in,
   input wire logic [7:0] record_oversampling_ratio_in,
   // per channel controls
   input wire logic pwr_l_in,
   input wire logic pwr_r_in,
   input wire logic mute_l_in,
   input wire logic mute_r_in,
   input wire logic signed [5:0] vol_l_in,
   input wire logic signed [5:0] vol_r_in,
   input wire logic [2:0] fine_l_in,
   input wire logic [2:0] fine_r_in,
   // coefficient write port
   input wire logic coef_wr_in,
   input wire logic [5:0] coef_addr_in,
   input wire logic signed [15:0] coef_data_in,
   // audio words and status
   output logic signed [15:0] sample_l_out,
   output logic signed [15:0] sample_r_out,
   output logic valid_l_out,
   output logic valid_r_out,
   output logic osr_err_out,
   output logic mono_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!nrst_in);

   pdmd_flt_e flt;
   logic [4:0] idx, grp, sub, opt, nfir_d, nfir_q;
   logic [2:0] nbq_d, nbq_q, l2_d, l2_q;
   logic [1:0] ord_d, ord_q, en_q, vld;
   logic mono_d, osr_ok;
   logic signed [15:0] smp [2];

   // decode the chain number into type and stage set
   always_comb begin
      idx = (rec_chain_in < REC_CHAIN_1 || rec_chain_in > REC_CHAIN_LAST) ?
            '0 : 5'(rec_chain_in - REC_CHAIN_1);
      grp = 5'(idx / CHAINS_PER_TYPE);
      sub = 5'(idx % CHAINS_PER_TYPE);
      flt = (grp == 5'h00) ? FLT_A : (grp == 5'h01) ? FLT_B : FLT_C;
      // upper half of each group is right-only
      mono_d = (sub >= MONO_FIRST);
      opt = mono_d ? 5'(sub - MONO_FIRST) : sub;
      nbq_d = (opt == OPT_BQ) ? ((flt == FLT_B) ? NBQ_B : NBQ_AC) : '0;
      nfir_d = (opt == OPT_FIR) ? ((flt == FLT_B) ? NFIR_B : NFIR_AC) : '0;
      ord_d = ORD_A;
      osr_ok = 1'b0;
      unique case (flt)
         // type A at 128 or 64
         FLT_A: begin
            ord_d = ORD_A;
            osr_ok = (record_oversampling_ratio_in == OSR_128) ||
                     (record_oversampling_ratio_in == OSR_64);
         end
         FLT_B: begin
            ord_d = ORD_B;
            osr_ok = (record_oversampling_ratio_in == OSR_64);
         end
         FLT_C: begin
            ord_d = ORD_C;
            osr_ok = (record_oversampling_ratio_in == OSR_32);
         end
      endcase
      l2_d = (record_oversampling_ratio_in == OSR_128) ? L2_128 :
             (record_oversampling_ratio_in == OSR_64) ? L2_64 : L2_32;
   end

   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         nbq_q <= '0;
         nfir_q <= '0;
         l2_q <= L2_64;
         ord_q <= ORD_A;
         en_q <= '0;
         osr_err_out <= 1'b0;
         mono_out <= 1'b0;
      end else begin
         nbq_q <= nbq_d;
         nfir_q <= nfir_d;
         l2_q <= l2_d;
         ord_q <= ord_d;
         // independent enables; a bad ratio keeps both off
         en_q[0] <= pwr_l_in && !mono_d && osr_ok;
         en_q[1] <= pwr_r_in && osr_ok;
         osr_err_out <= !osr_ok;
         mono_out <= mono_d;
      end
   end

   assign sample_l_out = smp[0];
   assign sample_r_out = smp[1];
   assign valid_l_out = vld[0];
   assign valid_r_out = vld[1];

   for (genvar c = 0; c < 2; c++) begin : g_ch
      pdmd_st_e st_q, nxt;
      logic signed [15:0] wd, x_q, ix1_q, iy1_q, op, cf, y;
      logic signed [15:0] coef_q [COEF_N];
      logic signed [15:0] bx1_q [5], bx2_q [5], by1_q [5], by2_q [5];
      logic signed [15:0] dl_q [24];
      logic signed [39:0] acc_q, acc_d;
      logic [5:0] ca;
      logic [4:0] tap_q;
      logic [2:0] bq_q, ts_q;
      logic tg, new_w, last, go_q;

      pdmd_cic u_cic (
         .pdm_clk_in(pdm_clk_in),
         .nrst_in(nrst_in),
         .pdm_data_in(c == 0 ? pdm_data_l_in : pdm_data_r_in),
         .en_in(en_q[c]),
         .l2_in(l2_q),
         .order_in(ord_q),
         .word_out(wd),
         .tgl_out(tg)
      );

      // word event crosses as a toggle; the word is held for a whole ratio
      always_ff @(posedge clk_in) begin
         if (!nrst_in) ts_q <= '0;
         else ts_q <= {ts_q[1:0], tg};
      end
      assign new_w = ts_q[1] ^ ts_q[2];

      always_ff @(posedge clk_in) begin
         for (int i = 0; i < COEF_N; i++) begin
            if (!nrst_in)
               coef_q[i] <= (i == IIR_BASE || i == FIR_BASE || (i >= BQ_BASE &&
                  i < FIR_BASE && (i - BQ_BASE) % BQ_TAPS == 0)) ? COEF_ONE : '0;
            else if (coef_wr_in && coef_addr_in == 6'(i))
               coef_q[i] <= coef_data_in;
         end
      end

      always_comb begin
         op = x_q;
         ca = 6'(IIR_BASE + int'(tap_q));
         last = 1'b0;
         unique case (st_q)
            ST_IIR: begin
               if (tap_q == 5'h01) op = ix1_q;
               else if (tap_q == 5'h02) op = iy1_q;
               last = (tap_q == 5'h02);
            end
            ST_BQ: begin
               ca = 6'(BQ_BASE + BQ_TAPS * int'(bq_q) + int'(tap_q));
               if (tap_q == 5'h01) op = bx1_q[bq_q];
               else if (tap_q == 5'h02) op = bx2_q[bq_q];
               else if (tap_q == 5'h03) op = by1_q[bq_q];
               else if (tap_q == 5'h04) op = by2_q[bq_q];
               last = (tap_q == 5'h04);
            end
            ST_FIR: begin
               ca = 6'(FIR_BASE + int'(tap_q));
               if (tap_q != 5'h00) op = dl_q[5'(tap_q - 5'h01)];
               last = (tap_q == 5'(nfir_q - 5'h01));
            end
            default: ;
         endcase
         cf = coef_q[ca];
         acc_d = acc_q + 40'(op) * 40'(cf);
         y = sat16(acc_d >>> COEF_FRAC);
         nxt = ST_OUT;
         if (st_q == ST_IIR && nbq_q != 3'h0) nxt = ST_BQ;
         else if (st_q != ST_FIR && nfir_q != 5'h00) nxt = ST_FIR;
      end

      // one multiply-accumulate per cycle through the chain
      always_ff @(posedge clk_in) begin
         if (!nrst_in || !en_q[c]) begin
            st_q <= ST_IDLE;
            tap_q <= '0;
            bq_q <= '0;
            acc_q <= '0;
            x_q <= '0;
            go_q <= 1'b0;
         end else begin
            go_q <= 1'b0;
            unique case (st_q)
               // every word starts in the iir
               ST_IDLE: if (new_w) begin
                  x_q <= wd;
                  st_q <= ST_IIR;
               end
               ST_IIR, ST_BQ, ST_FIR: begin
                  acc_q <= last ? '0 : acc_d;
                  tap_q <= last ? '0 : 5'(tap_q + 5'h01);
                  if (last) begin
                     x_q <= y;
                     if (st_q == ST_BQ && bq_q != 3'(nbq_q - 3'h1)) bq_q <= 3'(bq_q + 3'h1);
                     else begin
                        bq_q <= '0;
                        st_q <= nxt;
                     end
                  end
               end
               ST_OUT: begin
                  go_q <= 1'b1;
                  st_q <= ST_IDLE;
               end
               default: st_q <= ST_IDLE;
            endcase
         end
      end

      // filter histories update when a stage completes
      always_ff @(posedge clk_in) begin
         if (!nrst_in || !en_q[c]) begin
            ix1_q <= '0;
            iy1_q <= '0;
            for (int k = 0; k < 5; k++) begin
               bx1_q[k] <= '0;
               bx2_q[k] <= '0;
               by1_q[k] <= '0;
               by2_q[k] <= '0;
            end
            for (int k = 0; k < 24; k++) dl_q[k] <= '0;
         end else if (last) begin
            unique case (st_q)
               ST_IIR: begin
                  ix1_q <= x_q;
                  iy1_q <= y;
               end
               ST_BQ: begin
                  bx1_q[bq_q] <= x_q;
                  bx2_q[bq_q] <= bx1_q[bq_q];
                  by1_q[bq_q] <= y;
                  by2_q[bq_q] <= by1_q[bq_q];
               end
               ST_FIR: begin
                  dl_q[0] <= x_q;
                  for (int k = 1; k < 24; k++) dl_q[k] <= dl_q[k-1];
               end
               default: ;
            endcase
         end
      end

      pdmd_gain u_gain (
         .clk_in(clk_in),
         .nrst_in(nrst_in),
         .go_in(go_q),
         .x_in(x_q),
         .vol_in(c == 0 ? vol_l_in : vol_r_in),
         .fine_in(c == 0 ? fine_l_in : fine_r_in),
         .mute_in(c == 0 ? mute_l_in : mute_r_in),
         .y_out(smp[c]),
         .vld_out(vld[c])
      );

      a_iir_first: assert property (st_q == ST_IDLE && new_w && en_q[c]
         |=> st_q == ST_IIR && tap_q == 5'h00) else $error("word did not enter the iir");
      a_fir_len: assert property (st_q == ST_FIR |-> tap_q < nfir_q)
         else $error("fir tap beyond chain length");
      a_chain_bound: assert property ($rose(st_q == ST_IIR) && en_q[c]
         |-> ##[1:64] go_q || !en_q[c]) else $error("chain did not finish in time");
      a_off_silent: assert property ((!en_q[c])[*8] |-> !vld[c])
         else $error("powered-down channel produced a word");
      a_coef_store: assert property (coef_wr_in && coef_addr_in == 6'h1c
         |=> coef_q[FIR_BASE] == $past(coef_data_in)) else $error("coefficient not stored");
   end

   a_mono_left_off: assert property (rec_chain_in == REC_CHAIN_4 |=> !en_q[0])
      else $error("mono chain left channel enabled");
   a_osr_type_a: assert property (rec_chain_in == REC_CHAIN_2 &&
      record_oversampling_ratio_in == OSR_128 |=> !osr_err_out && nbq_q == NBQ_AC)
      else $error("type A chain rejected ratio 128");
   a_osr_type_b: assert property (rec_chain_in == REC_CHAIN_9 &&
      record_oversampling_ratio_in != OSR_64 |=> osr_err_out && en_q == 2'h0)
      else $error("type B chain accepted a wrong ratio");
   a_osr_type_c: assert property (rec_chain_in == REC_CHAIN_13 &&
      record_oversampling_ratio_in == OSR_32 |=> !osr_err_out && ord_q == ORD_C)
      else $error("type C chain rejected ratio 32");
endmodule

// ---- verif/pdmd_mic_model.sv ----
// pdm microphone model: gated link clock and random bit stream
`timescale 1ns/10ps
module pdmd_mic_model (
   // control from the bench
   input wire logic run_in,
   // link to the record path
   output logic pdm_clk_out,
   output logic pdm_data_out
);
   initial begin
      pdm_clk_out = 1'b0;
      pdm_data_out = 1'b0;
      #17;
      forever begin
         #40;
         if (run_in) begin
            pdm_clk_out = ~pdm_clk_out;
            // new bit set up away from the sampling edge
            if (!pdm_clk_out) pdm_data_out = 1'($urandom);
         end else begin
            // clock stands still, released line keeps changing
            pdm_clk_out = 1'b0;
            pdm_data_out = ~pdm_data_out;
         end
      end
   end
endmodule

// ---- verif/tb.sv ----
// self-checking bench for the pdm record path
`timescale 1ns/10ps
module tb;
   import pdmd_pkg::*;
   logic clk_in, nrst_in, run, pdm_clk, pdm_data, pwr_l, pwr_r, mute_l, mute_r, coef_wr;
   logic [4:0] chain;
   logic [7:0] ratio;
   logic signed [5:0] vol_l, vol_r;
   logic [2:0] fine_l, fine_r;
   logic [5:0] coef_addr;
   logic signed [15:0] coef_data, sample_l, sample_r;
   logic valid_l, valid_r, osr_err, mono;
   int n_errors, tests_run, cnt_l, cnt_r, t, v;
   logic [7:0] rv;
   logic exp_err;
   logic signed [15:0] ql[$], qr[$];
   logic [5:0] ca[3] = '{6'h00, 6'h03, 6'h1c};

   pdmd_top u_pdmd_top (.clk_in(clk_in), .nrst_in(nrst_in), .pdm_clk_in(pdm_clk),
      .pdm_data_l_in(pdm_data), .pdm_data_r_in(pdm_data), .rec_chain_in(chain),
      .record_oversampling_ratio_in(ratio), .pwr_l_in(pwr_l), .pwr_r_in(pwr_r),
      .mute_l_in(mute_l), .mute_r_in(mute_r), .vol_l_in(vol_l), .vol_r_in(vol_r),
      .fine_l_in(fine_l), .fine_r_in(fine_r), .coef_wr_in(coef_wr), .coef_addr_in(coef_addr),
      .coef_data_in(coef_data), .sample_l_out(sample_l), .sample_r_out(sample_r),
      .valid_l_out(valid_l), .valid_r_out(valid_r), .osr_err_out(osr_err), .mono_out(mono));
   pdmd_mic_model u_pdmd_mic_model (.run_in(run), .pdm_clk_out(pdm_clk),
      .pdm_data_out(pdm_data));

   initial begin
      clk_in = 1'b0;
      forever #20 clk_in = ~clk_in;
   end

   // collect words where the registered outputs have settled
   always @(negedge clk_in) begin
      if (valid_l === 1'b1) begin
         cnt_l++;
         ql.push_back(sample_l);
      end
      if (valid_r === 1'b1) begin
         cnt_r++;
         qr.push_back(sample_r);
      end
   end

   task automatic report_and_stop();
      $display("errors %0d, checks %0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   task automatic bad(input string msg);
      n_errors++;
      $display("BAD %0t %s", $time, msg);
   endtask

   task automatic cmp_bit(input logic got, input logic exp);
      tests_run++;
      if (got !== exp) bad("flag mismatch");
   endtask

   task automatic cmp_cnt(input int got, input int lo, input int hi);
      tests_run++;
      if (got < lo || got > hi) bad($sformatf("count %0d not in %0d..%0d", got, lo, hi));
   endtask

   task automatic cmp_word(input logic signed [15:0] got, input int exp, input int tol);
      tests_run++;
      if ((^got === 1'bx) || (int'(got) - exp > tol) || (exp - int'(got) > tol))
         bad($sformatf("word %0d, expected %0d", got, exp));
   endtask

   function automatic int gain_model(input int x, input int vd, input int f);
      real g;
      int y;
      g = 10.0 ** ((vd - 0.1 * f) / 20.0);
      y = $rtoi(x * g + ((x < 0) ? -0.5 : 0.5));
      return (y > 32767) ? 32767 : ((y < -32768) ? -32768 : y);
   endfunction

   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk_in);
   endtask

   // skip in-flight words, then count over a window of link words
   task automatic window(input int words);
      wait_clk(40);
      ql.delete();
      qr.delete();
      cnt_l = 0;
      cnt_r = 0;
      wait_clk(words * 2 * int'(ratio));
   endtask

   task automatic run_words(input int c, input logic [7:0] r, input logic pl, input logic pr);
      @(posedge clk_in);
      chain <= 5'(c);
      ratio <= r;
      // ratio settled before the channels power up
      wait_clk(2);
      pwr_l <= pl;
      pwr_r <= pr;
      wait_clk(4 * int'(r));
      window(4);
   endtask

   task automatic power_off();
      @(posedge clk_in);
      pwr_l <= 1'b0;
      pwr_r <= 1'b0;
      wait_clk(8);
   endtask

   task automatic coef_write(input logic [5:0] a, input logic signed [15:0] d);
      @(posedge clk_in);
      coef_wr <= 1'b1;
      coef_addr <= a;
      coef_data <= d;
      @(posedge clk_in);
      coef_wr <= 1'b0;
   endtask

   // mode 0: channels equal, 1: left silent, 2: right is scaled left, 3: right silent
   task automatic check_pairs(input int mode);
      int n, tol;
      n = (ql.size() < qr.size()) ? ql.size() : qr.size();
      for (int i = 0; i < n; i++) begin
         if (mode == 0) cmp_word(qr[i], ql[i], 0);
         else if (mode == 1) cmp_word(ql[i], 0, 0);
         else if (mode == 3) cmp_word(qr[i], 0, 0);
         else begin
            tol = 2 + ((ql[i] > 0) ? ql[i] : -ql[i]) / 256;
            cmp_word(qr[i], gain_model(ql[i], vol_r, fine_r), tol);
         end
      end
   endtask

   initial begin
      #4000000;
      bad("run did not finish");
      report_and_stop();
   end

   initial begin
      void'($urandom(24));
      {nrst_in, pwr_l, pwr_r, mute_l, mute_r, coef_wr, vol_l, vol_r, fine_l, fine_r} = '0;
      {coef_addr, coef_data} = '0;
      chain = REC_CHAIN_1;
      ratio = OSR_64;
      run = 1'b1;
      wait_clk(8);
      nrst_in <= 1'b1;
      @(negedge clk_in);
      cmp_bit(valid_l | valid_r | osr_err | mono, 1'b0);
      for (int c = 0; c < 20; c++) begin
         for (int k = 0; k < 4; k++) begin
            rv = 8'h10 << k;
            @(posedge clk_in);
            chain <= 5'(c);
            ratio <= rv;
            wait_clk(2);
            @(negedge clk_in);
            t = (c == 0 || c > 18) ? 0 : c - 1;
            exp_err = (t / 6 == 0) ? !(rv == OSR_128 || rv == OSR_64) :
                      (t / 6 == 1) ? rv != OSR_64 : rv != OSR_32;
            cmp_bit(osr_err, exp_err);
            cmp_bit(mono, (t % 6) >= 3);
         end
      end
      for (int c = 1; c <= 18; c++) begin
         t = c - 1;
         rv = (t / 6 == 0) ? ((c % 2) ? OSR_128 : OSR_64) : (t / 6 == 1) ? OSR_64 : OSR_32;
         run_words(c, rv, 1'b1, 1'b1);
         cmp_cnt(cnt_r, 3, 5);
         cmp_cnt(cnt_l, (t % 6 >= 3) ? 0 : 3, (t % 6 >= 3) ? 0 : 5);
         if (t % 6 < 3) check_pairs(0);
         power_off();
      end
      run_words(13, OSR_32, 1'b0, 1'b1);
      cmp_cnt(cnt_l, 0, 0);
      cmp_cnt(cnt_r, 3, 5);
      power_off();
      run_words(13, OSR_64, 1'b1, 1'b1);
      cmp_cnt(cnt_l + cnt_r, 0, 0);
      cmp_bit(osr_err, 1'b1);
      power_off();
      for (int i = 0; i < 3; i++) begin
         v = (i == 0) ? 20 : (i == 1) ? -12 : int'($urandom_range(32)) - 12;
         @(posedge clk_in);
         vol_r <= 6'(v);
         fine_r <= 3'($urandom_range(4));
         run_words(1, OSR_64, 1'b1, 1'b1);
         check_pairs(2);
         power_off();
      end
      vol_r <= '0;
      fine_r <= '0;
      for (int i = 0; i < 3; i++) begin
         coef_write(ca[i], 16'sh0000);
         run_words(i + 1, OSR_64, 1'b1, 1'b1);
         cmp_cnt(cnt_l, 3, 5);
         check_pairs(1);
         power_off();
         coef_write(ca[i], COEF_ONE);
      end
      mute_l <= 1'b1;
      run_words(13, OSR_32, 1'b1, 1'b1);
      cmp_cnt(cnt_l, 3, 5);
      check_pairs(1);
      mute_l <= 1'b0;
      window(4);
      check_pairs(0);
      mute_r <= 1'b1;
      window(4);
      check_pairs(3);
      mute_r <= 1'b0;
      power_off();
      report_and_stop();
   end
endmodule
